/* design/tscm_top.sv */
// tscm_top: register map, operating modes and master tick of an
// eight electrode touch controller, with its serial register port.
// assumes SCL_CLK is the host's serial clock and SDA an open drain
// line resolved outside; ATTENTION_PIN is asynchronous.
`timescale 1ns/1ps
`default_nettype none
module tscm_top
   import tscm_pkg::*;
#(
   parameter int MS_COUNT = MS_CYCLES
) (
   // system
   input wire logic MCLK,
   input wire logic RST_B,
   input wire logic CE,
   // serial register port
   input wire logic SCL_CLK,
   input wire logic SDA_IN,
   output logic SDA_OUT,
   output logic SDA_OE,
   // pins
   input wire logic ATTENTION_PIN,
   output logic IRQ_B,
   // to the sensing logic
   output logic [1:0] MODE,
   output logic [7:0] SCAN_MASK,
   output logic [2:0] TOUCH_LIMIT,
   output logic TICK,
   output logic SCAN_STROBE
);
   typedef enum logic [3:0] {
      lk_idle, lk_addr, lk_addr_ack, lk_ptr, lk_ptr_ack,
      lk_wdata, lk_wdata_ack, lk_rdata, lk_rdata_ack
   } tscm_link_e;

   // ----------------------------------------------------------
   // link side, clocked by the host's serial clock
   // ----------------------------------------------------------
   tscm_link_e lk_state;
   logic sda_pos;
   logic [1:0] lk_ok;
   logic [2:0] bit_cnt;
   logic [6:0] shift;
   logic [7:0] tx;
   logic [7:0] ptr;
   logic [7:0] ptr_val;
   logic ptr_tog;
   logic [7:0] wr_addr;
   logic [7:0] wr_data;
   logic wr_tog;
   logic [7:0] rd_data;
   logic bus_on;
   logic start_seen;
   logic [7:0] rx_byte;

   assign start_seen = sda_pos & ~SDA_IN;
   assign rx_byte = {shift, sda_pos};

   always_ff @(posedge SCL_CLK or negedge RST_B) begin
      if (!RST_B) begin
         sda_pos <= 1'b1;
      end else begin
         sda_pos <= SDA_IN;
      end
   end

   // bus allowed level from the system side
   always_ff @(negedge SCL_CLK or negedge RST_B) begin
      if (!RST_B) begin
         lk_ok <= 2'b00;
      end else begin
         lk_ok <= {lk_ok[0], bus_on};
      end
   end

   always_ff @(negedge SCL_CLK or negedge RST_B) begin
      if (!RST_B) begin
         lk_state <= lk_idle;
         bit_cnt <= 3'h0;
         shift <= 7'h00;
         tx <= 8'h00;
         ptr <= 8'h00;
         ptr_val <= 8'h00;
         ptr_tog <= 1'b0;
         wr_addr <= 8'h00;
         wr_data <= 8'h00;
         wr_tog <= 1'b0;
         SDA_OE <= 1'b0;
      end else if (start_seen) begin
         lk_state <= lk_addr;
         bit_cnt <= 3'h0;
         SDA_OE <= 1'b0;
      end else begin
         shift <= rx_byte[6:0];
         bit_cnt <= bit_cnt + 3'h1;
         unique case (lk_state)
            lk_idle: begin
               bit_cnt <= 3'h0;
            end
            lk_addr: begin
               if (bit_cnt == 3'h7) begin
                  // silent in off stop and duty run
                  // bus gated
                  if (rx_byte[7:1] == DEV_ADDR && lk_ok[1]) begin
                     lk_state <= lk_addr_ack;
                     SDA_OE <= 1'b1;
                     tx <= {7'h00, rx_byte[0]};
                  end else begin
                     lk_state <= lk_idle;
                  end
               end
            end
            lk_addr_ack: begin
               bit_cnt <= 3'h0;
               if (tx[0]) begin
                  lk_state <= lk_rdata;
                  tx <= rd_data;
                  SDA_OE <= ~rd_data[7];
               end else begin
                  lk_state <= lk_ptr;
                  SDA_OE <= 1'b0;
               end
            end
            lk_ptr: begin
               if (bit_cnt == 3'h7) begin
                  ptr <= rx_byte;
                  ptr_val <= rx_byte;
                  ptr_tog <= ~ptr_tog;
                  SDA_OE <= 1'b1;
                  lk_state <= lk_ptr_ack;
               end
            end
            lk_ptr_ack, lk_wdata_ack: begin
               bit_cnt <= 3'h0;
               SDA_OE <= 1'b0;
               lk_state <= lk_wdata;
            end
            lk_wdata: begin
               if (bit_cnt == 3'h7) begin
                  wr_addr <= ptr;
                  wr_data <= rx_byte;
                  wr_tog <= ~wr_tog;
                  ptr <= ptr + 8'h01;
                  SDA_OE <= 1'b1;
                  lk_state <= lk_wdata_ack;
               end
            end
            lk_rdata: begin
               tx <= {tx[6:0], 1'b0};
               SDA_OE <= ~tx[6];
               if (bit_cnt == 3'h7) begin
                  SDA_OE <= 1'b0;
                  lk_state <= lk_rdata_ack;
               end
            end
            lk_rdata_ack: begin
               bit_cnt <= 3'h0;
               if (!sda_pos) begin
                  lk_state <= lk_rdata;
                  tx <= rd_data;
                  SDA_OE <= ~rd_data[7];
               end else begin
                  lk_state <= lk_idle;
               end
            end
            default: begin
               lk_state <= lk_idle;
            end
         endcase
      end
   end

   always_ff @(negedge SCL_CLK or negedge RST_B) begin
      if (!RST_B) begin
         SDA_OUT <= 1'b0;
      end else begin
         SDA_OUT <= 1'b0;
      end
   end

   // ----------------------------------------------------------
   // crossings into the system clock
   // ----------------------------------------------------------
   logic [2:0] wr_sync;
   logic [2:0] ptr_sync;
   logic [2:0] attention_pin_sync;
   logic wr_evt;
   logic ptr_evt;
   logic attention_pin_fall;

   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         wr_sync <= 3'h0;
         ptr_sync <= 3'h0;
         attention_pin_sync <= 3'h7;
      end else if (CE) begin
         wr_sync <= {wr_sync[1:0], wr_tog};
         ptr_sync <= {ptr_sync[1:0], ptr_tog};
         attention_pin_sync <= {attention_pin_sync[1:0], ATTENTION_PIN};
      end
   end

   assign wr_evt = wr_sync[2] ^ wr_sync[1];
   assign ptr_evt = ptr_sync[2] ^ ptr_sync[1];
   assign attention_pin_fall = attention_pin_sync[2] & ~attention_pin_sync[1];

   // ----------------------------------------------------------
   // register file
   // ----------------------------------------------------------
   logic [7:0] mem [ADDR_PADCFG:ADDR_STUCK];
   logic [7:0] cfg;
   logic run;
   logic soft_rst;
   logic map_wr;

   function automatic logic [7:0] rst_val(input logic [7:0] a);
      unique case (a)
         ADDR_PADCFG: rst_val = RST_PADCFG;
         ADDR_MASK: rst_val = RST_MASK;
         ADDR_LIMIT: rst_val = RST_LIMIT;
         ADDR_TICK: rst_val = RST_TICK;
         ADDR_SCAN: rst_val = RST_SCAN;
         ADDR_SOUND: rst_val = RST_SOUND;
         ADDR_LOWPWR: rst_val = RST_LOWPWR;
         ADDR_STUCK: rst_val = RST_STUCK;
         default: rst_val = RST_THR;
      endcase
   endfunction

   function automatic logic [7:0] clamp(input logic [7:0] a,
                                        input logic [7:0] d);
      clamp = d;
      if (a == ADDR_TICK && d > TICK_MAX) begin
         clamp = TICK_MAX;
      end
      if (a == ADDR_SCAN && d > SCAN_MAX) begin
         clamp = SCAN_MAX;
      end
   endfunction

   assign run = cfg[CFG_SCAN];
   assign soft_rst = wr_evt && wr_addr == ADDR_CFG && !wr_data[CFG_SRST];
   assign map_wr = wr_evt && !run && wr_addr >= ADDR_PADCFG &&
                   wr_addr <= ADDR_STUCK;

   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         for (int i = ADDR_PADCFG; i <= ADDR_STUCK; i++) begin
            mem[i] <= rst_val(8'(i));
         end
      end else if (CE) begin
         if (soft_rst) begin
            for (int i = ADDR_PADCFG; i <= ADDR_STUCK; i++) begin
               mem[i] <= rst_val(8'(i));
            end
         end else if (map_wr) begin
            mem[wr_addr] <= clamp(wr_addr, wr_data);
         end
      end
   end

   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         cfg <= RST_CFG;
      end else if (CE) begin
         if (soft_rst) begin
            cfg <= RST_CFG;
         end else if (wr_evt && wr_addr == ADDR_CFG) begin
            cfg <= wr_data;
         end
         if (attention_pin_fall) begin
            cfg[CFG_DUTY_N] <= 1'b1;
         end
      end
   end

   // read side
   logic [7:0] rd_ptr;

   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         rd_ptr <= 8'h00;
      end else if (CE) begin
         if (ptr_evt) begin
            rd_ptr <= ptr_val;
         end else if (wr_evt) begin
            rd_ptr <= wr_addr + 8'h01;
         end
      end
   end

   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         rd_data <= RST_QUEUE;
      end else if (CE) begin
         if (rd_ptr == ADDR_QUEUE) begin
            rd_data <= RST_QUEUE;
         end else if (rd_ptr == ADDR_FAULT) begin
            rd_data <= RST_FAULT;
         end else if (rd_ptr == ADDR_PADST) begin
            rd_data <= RST_PADST;
         end else if (rd_ptr <= ADDR_STUCK) begin
            rd_data <= mem[rd_ptr];
         end else if (rd_ptr == ADDR_CFG) begin
            rd_data <= cfg;
         end else if (rd_ptr == ADDR_REV) begin
            rd_data <= REV_INFO;
         end else begin
            rd_data <= 8'h00;
         end
      end
   end

   // ----------------------------------------------------------
   // operating mode
   // ----------------------------------------------------------
   tscm_mode_e mode;
   tscm_mode_e next_mode;
   logic scanning;

   // mode from scan and duty bits
   always_comb begin
      unique case ({cfg[CFG_SCAN], cfg[CFG_DUTY_N]})
         2'b11: next_mode = continuous_run;
         2'b10: next_mode = duty_cycled_run;
         2'b01: next_mode = configurable_stop;
         2'b00: next_mode = off_stop;
      endcase
   end

   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         mode <= configurable_stop;
         bus_on <= 1'b1;
      end else if (CE) begin
         mode <= next_mode;
         bus_on <= next_mode == continuous_run ||
                   next_mode == configurable_stop;
      end
   end

   assign scanning = mode == continuous_run || mode == duty_cycled_run;

   // ----------------------------------------------------------
   // master tick and scan strobe
   // ----------------------------------------------------------
   logic [31:0] ms_cnt;
   logic [7:0] tick_ms;
   logic [7:0] tick_len;
   logic [7:0] scan_cnt;
   logic [7:0] scan_len;
   logic ms_evt;
   logic tick_evt;

   // period register only in continuous run
   assign tick_len = mode == continuous_run ?
                     mem[ADDR_TICK] + TICK_BASE_MS : STOP_TICK_MS;
   assign scan_len = mem[ADDR_SCAN] == 8'h00 ? 8'h01 : mem[ADDR_SCAN];
   assign ms_evt = ms_cnt == 32'(MS_COUNT - 1);
   assign tick_evt = ms_evt && tick_ms + 8'h01 >= tick_len;

   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         ms_cnt <= 32'h0;
         tick_ms <= 8'h00;
      end else if (CE) begin
         if (mode == off_stop || ms_evt) begin
            ms_cnt <= 32'h0;
         end else begin
            ms_cnt <= ms_cnt + 32'h1;
         end
         if (mode == off_stop || tick_evt) begin
            tick_ms <= 8'h00;
         end else if (ms_evt) begin
            tick_ms <= tick_ms + 8'h01;
         end
      end
   end

   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         scan_cnt <= 8'h00;
         TICK <= 1'b0;
         SCAN_STROBE <= 1'b0;
      end else if (CE) begin
         TICK <= tick_evt;
         SCAN_STROBE <= 1'b0;
         if (!scanning) begin
            scan_cnt <= 8'h00;
         end else if (tick_evt) begin
            if (scan_cnt + 8'h01 >= scan_len) begin
               scan_cnt <= 8'h00;
               SCAN_STROBE <= mem[ADDR_PADCFG][PADCFG_ON];
            end else begin
               scan_cnt <= scan_cnt + 8'h01;
            end
         end
      end
   end

   // ----------------------------------------------------------
   // outputs to the sensing logic and the interrupt pin
   // ----------------------------------------------------------
   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         MODE <= 2'(configurable_stop);
         SCAN_MASK <= RST_MASK;
         TOUCH_LIMIT <= RST_LIMIT[2:0];
         IRQ_B <= 1'b1;
      end else if (CE) begin
         MODE <= 2'(mode);
         SCAN_MASK <= mem[ADDR_MASK];
         TOUCH_LIMIT <= mem[ADDR_LIMIT][2:0];
         IRQ_B <= 1'b1;
      end
   end

   // ----------------------------------------------------------
   // checks
   // ----------------------------------------------------------
   logic fresh;

   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         fresh <= 1'b1;
      end else begin
         fresh <= 1'b0;
      end
   end

   sequence seq_mask_wr;
      CE && wr_evt && wr_addr == ADDR_MASK;
   endsequence

   chk_mode_follow: assert property (@(posedge MCLK) disable iff (!RST_B)
      CE && cfg[CFG_SCAN] && !cfg[CFG_DUTY_N] |=> mode == duty_cycled_run)
      else $error("mode does not follow bits");
   chk_cfg_store: assert property (@(posedge MCLK) disable iff (!RST_B)
      CE && wr_evt && wr_addr == ADDR_CFG && wr_data[CFG_SRST]
      && !attention_pin_fall |=> cfg == $past(wr_data))
      else $error("configuration write lost");
   chk_run_block: assert property (@(posedge MCLK) disable iff (!RST_B)
      seq_mask_wr and run |=> ##1 $stable(SCAN_MASK))
      else $error("write taken in run mode");
   chk_mask_take: assert property (@(posedge MCLK) disable iff (!RST_B)
      (seq_mask_wr and !run) ##1 CE |=> SCAN_MASK == $past(wr_data, 2))
      else $error("stop mode mask write lost");
   chk_attention_pin_duty: assert property (@(posedge MCLK) disable iff (!RST_B)
      CE && attention_pin_fall |=> cfg[CFG_DUTY_N] ##1 CE [*1])
      else $error("attention edge ignored");
   chk_irq_high: assert property (@(posedge MCLK) disable iff (!RST_B)
      IRQ_B)
      else $error("interrupt line not high");
   chk_reset_cfg: assert property (@(posedge MCLK) disable iff (!RST_B)
      fresh |-> cfg == RST_CFG && MODE == 2'(configurable_stop))
      else $error("configuration reset value wrong");
   chk_reset_map: assert property (@(posedge MCLK) disable iff (!RST_B)
      fresh |-> mem[ADDR_PADCFG] == RST_PADCFG && TOUCH_LIMIT == 3'h4
      && mem[ADDR_TICK] == RST_TICK && mem[ADDR_SCAN] == RST_SCAN
      && mem[ADDR_SOUND] == RST_SOUND && mem[ADDR_LOWPWR] == 8'h00
      && mem[ADDR_STUCK] == 8'h00 && mem[ADDR_LIMIT] == RST_LIMIT)
      else $error("register map reset value wrong");
   chk_tick_gap: assert property (@(posedge MCLK) disable iff (!RST_B)
      TICK |=> !TICK)
      else $error("tick longer than one cycle");
   chk_strobe_run: assert property (@(posedge MCLK) disable iff (!RST_B)
      SCAN_STROBE |-> $past(scanning))
      else $error("scan strobe outside run mode");
   chk_rev_fixed: assert property (@(posedge MCLK) disable iff (!RST_B)
      CE && rd_ptr == ADDR_REV |=> rd_data == REV_INFO)
      else $error("revision value changed");
   chk_off_silent: assert property (@(negedge SCL_CLK) disable iff (!RST_B)
      lk_state == lk_addr && bit_cnt == 3'h7 && !lk_ok[1] && !start_seen
      |=> !SDA_OE)
      else $error("address acknowledged while off");
endmodule // tscm_top
`default_nettype wire

/* design/tscm_pkg.sv */
// tscm_pkg: register map, reset values, fields and timing of the
// touch sensor configuration and mode block.
// assumes a 100 MHz system clock.
`default_nettype none
package tscm_pkg;
   // ----------------------------------------------------------
   // register offsets
   // ----------------------------------------------------------
   localparam logic [7:0] ADDR_QUEUE = 8'h00;
   localparam logic [7:0] ADDR_FAULT = 8'h01;
   localparam logic [7:0] ADDR_PADST = 8'h02;
   localparam logic [7:0] ADDR_PADCFG = 8'h03;
   localparam logic [7:0] ADDR_MASK = 8'h0C;
   localparam logic [7:0] ADDR_LIMIT = 8'h0D;
   localparam logic [7:0] ADDR_TICK = 8'h0E;
   localparam logic [7:0] ADDR_SCAN = 8'h0F;
   localparam logic [7:0] ADDR_SOUND = 8'h10;
   localparam logic [7:0] ADDR_LOWPWR = 8'h11;
   localparam logic [7:0] ADDR_STUCK = 8'h12;
   localparam logic [7:0] ADDR_CFG = 8'h13;
   localparam logic [7:0] ADDR_REV = 8'h14;
   // ----------------------------------------------------------
   // reset values
   // ----------------------------------------------------------
   localparam logic [7:0] RST_QUEUE = 8'h40;
   localparam logic [7:0] RST_FAULT = 8'h00;
   localparam logic [7:0] RST_PADST = 8'h00;
   localparam logic [7:0] RST_PADCFG = 8'h81;
   localparam logic [7:0] RST_THR = 8'h00;
   localparam logic [7:0] RST_MASK = 8'hFF;
   localparam logic [7:0] RST_LIMIT = 8'h04;
   localparam logic [7:0] RST_TICK = 8'h05;
   localparam logic [7:0] RST_SCAN = 8'h01;
   localparam logic [7:0] RST_SOUND = 8'h01;
   localparam logic [7:0] RST_LOWPWR = 8'h00;
   localparam logic [7:0] RST_STUCK = 8'h00;
   localparam logic [7:0] RST_CFG = 8'h14;
   // revision value is arbitrary
   localparam logic [7:0] REV_INFO = 8'h3C;
   // bus address is arbitrary
   localparam logic [6:0] DEV_ADDR = 7'h5C;
   // ----------------------------------------------------------
   // fields and limits
   // ----------------------------------------------------------
   localparam int CFG_SRST = 4;
   localparam int CFG_DUTY_N = 2;
   localparam int CFG_SCAN = 0;
   localparam int PADCFG_ON = 0;
   localparam logic [7:0] TICK_MAX = 8'h1A;
   localparam logic [7:0] SCAN_MAX = 8'h1F;
   // ----------------------------------------------------------
   // timing
   // ----------------------------------------------------------
   localparam int CLK_NS = 10;
   localparam int MS_NS = 1000000;
   localparam int MS_CYCLES = MS_NS / CLK_NS;
   localparam logic [7:0] TICK_BASE_MS = 8'h05;
   localparam logic [7:0] STOP_TICK_MS = 8'h08;
   typedef enum logic [1:0] {
      off_stop, duty_cycled_run, configurable_stop, continuous_run
   } tscm_mode_e;
endpackage
`default_nettype wire

/* verif/tscm_host.sv */
// tscm_host: serial host master for the register port.
// assumes an open drain data line with a pull-up beside it.
`timescale 1ns/1ps
`default_nettype none
module tscm_host
   import tscm_pkg::*;
(
   // serial lines
   output logic scl,
   output logic sda_low,
   input wire logic sda
);
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   // ----------------
   // framing
   // ----------------
   // one bit, data moves only while clock is low
   task automatic bit_io(input logic b, output logic r);
      #8 sda_low = ~b;
      #8 scl = 1'b1;
      r = sda;
      #16 scl = 1'b0;
   endtask
   task automatic start();
      scl = 1'b0;
      sda_low = 1'b0;
      #16 scl = 1'b1;
      #8 sda_low = 1'b1;
      #8 scl = 1'b0;
   endtask
   // clock stands high between frames
   task automatic stop();
      #8 sda_low = 1'b1;
      #8 scl = 1'b1;
      #8 sda_low = 1'b0;
      #8;
   endtask
   task automatic xbyte(input logic [7:0] d, output logic [7:0] q,
      output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], r);
         q[i] = r;
      end
      bit_io(1'b1, r);
      ack = ~r;
   endtask
   // pointer then data, all inside one frame
   task automatic wr(input logic [7:0] p, input logic [7:0] d,
      output logic ack);
      logic [7:0] q;
      logic a0, a1, a2;
      start();
      xbyte({DEV_ADDR, 1'b0}, q, a0);
      xbyte(p, q, a1);
      xbyte(d, q, a2);
      stop();
      ack = a0 & a1 & a2;
   endtask
   task automatic rd(input logic [7:0] p, output logic [7:0] q,
      output logic ack);
      logic a0;
      wr_ptr: begin
         start();
         xbyte({DEV_ADDR, 1'b0}, q, a0);
         xbyte(p, q, ack);
         stop();
      end
      #120 start();
      xbyte({DEV_ADDR, 1'b1}, q, ack);
      xbyte(8'hFF, q, a0);
      stop();
   endtask
endmodule // tscm_host
`default_nettype wire

/* verif/tb_top.sv */
// tb_top: scenarios for the touch sensor mode block.
// assumes MS_COUNT 10, so a 10 ms tick is 100 MCLK cycles.
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import tscm_pkg::*;
;
   logic mclk, rst_b, ce, attention_pin, sda, sda_low, scl, a;
   logic sda_oe, irq_b, tick, strobe;
   logic [1:0] mode;
   logic [7:0] mask, q;
   logic sda_out;
   logic [2:0] limit;
   int n_errors = 0;
   int n_compared = 0;
   assign sda = ~(sda_oe | sda_low);
   tscm_top #(.MS_COUNT(10)) tscm_top_inst (.MCLK(mclk), .RST_B(rst_b),
      .CE(ce), .SCL_CLK(scl), .SDA_IN(sda), .SDA_OUT(sda_out),
      .SDA_OE(sda_oe),
      .ATTENTION_PIN(attention_pin), .IRQ_B(irq_b), .MODE(mode), .SCAN_MASK(mask),
      .TOUCH_LIMIT(limit), .TICK(tick), .SCAN_STROBE(strobe));
   tscm_host tscm_host_inst (.scl(scl), .sda_low(sda_low), .sda(sda));
   // ----------------
   // helpers
   // ----------------
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic tally_and_finish();
      if (n_errors == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic wr(input logic [7:0] p, input logic [7:0] d);
      tscm_host_inst.wr(p, d, a);
      repeat (10) @(negedge mclk);
   endtask
   task automatic attention();
      @(posedge mclk) attention_pin <= 1'b0;
      repeat (3) @(posedge mclk);
      attention_pin <= 1'b1;
      repeat (10) @(negedge mclk);
   endtask
   // ----------------
   // scenarios
   // ----------------
   task automatic t_reset();
      logic [7:0] ad [10] = '{8'h03, 8'h0C, 8'h0D, 8'h0E, 8'h0F, 8'h10,
         8'h11, 8'h12, 8'h13, 8'h14};
      logic [7:0] ex [10] = '{8'h81, 8'hFF, 8'h04, 8'h05, 8'h01, 8'h01,
         8'h00, 8'h00, 8'h14, REV_INFO};
      cmp({6'h0, mode}, 8'h02);
      cmp({7'h0, irq_b}, 8'h01);
      cmp({7'h0, sda_out}, 8'h00);
      cmp(mask, 8'hFF);
      cmp({5'h0, limit}, 8'h04);
      for (int i = 0; i < 10; i++) begin
         tscm_host_inst.rd(ad[i], q, a);
         cmp(q, ex[i]);
      end
   endtask
   task automatic t_config();
      wr(ADDR_MASK, 8'h5A);
      cmp(mask, 8'h5A);
      wr(ADDR_LIMIT, 8'h07);
      cmp({5'h0, limit}, 8'h07);
      wr(ADDR_LIMIT, 8'h00);
      cmp({5'h0, limit}, 8'h00);
      wr(ADDR_TICK, 8'hFF);
      tscm_host_inst.rd(ADDR_TICK, q, a);
      cmp(q, TICK_MAX);
      wr(ADDR_TICK, RST_TICK);
      wr(ADDR_SCAN, 8'hFF);
      tscm_host_inst.rd(ADDR_SCAN, q, a);
      cmp(q, SCAN_MAX);
      wr(ADDR_SCAN, RST_SCAN);
      wr(8'h14, 8'h00);
      tscm_host_inst.rd(8'h14, q, a);
      cmp(q, REV_INFO);
   endtask
   task automatic t_run();
      int n;
      wr(ADDR_CFG, 8'h15);
      cmp({6'h0, mode}, 8'h03);
      n = 0;
      while (tick !== 1'b1 && n < 300) begin
         @(negedge mclk);
         n++;
      end
      cmp({7'h0, strobe}, 8'h01);
      n = 0;
      do begin
         @(negedge mclk);
         n++;
      end while (tick !== 1'b1 && n < 300);
      cmp(n[7:0], 8'h64);
      wr(ADDR_MASK, 8'h00);
      cmp({7'h0, a}, 8'h01);
      cmp(mask, 8'h5A);
      tscm_host_inst.rd(ADDR_CFG, q, a);
      cmp(q, 8'h15);
   endtask
   task automatic t_duty_off();
      wr(ADDR_CFG, 8'h11);
      cmp({6'h0, mode}, 8'h01);
      tscm_host_inst.rd(ADDR_CFG, q, a);
      cmp({7'h0, a}, 8'h00);
      attention();
      cmp({6'h0, mode}, 8'h03);
      wr(ADDR_CFG, 8'h10);
      cmp({6'h0, mode}, 8'h00);
      wr(ADDR_MASK, 8'h00);
      cmp({7'h0, a}, 8'h00);
      attention();
      cmp({6'h0, mode}, 8'h02);
      cmp(mask, 8'h5A);
   endtask
   task automatic t_soft_reset();
      wr(ADDR_MASK, 8'h33);
      wr(ADDR_CFG, 8'h04);
      cmp(mask, 8'hFF);
      tscm_host_inst.rd(ADDR_CFG, q, a);
      cmp(q, 8'h14);
   endtask
   // ----------------
   // run
   // ----------------
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   initial begin
      #300000;
      n_errors++;
      tally_and_finish();
   end
   initial begin
      rst_b = 1'b0;
      ce = 1'b1;
      attention_pin = 1'b1;
      repeat (6) @(posedge mclk);
      rst_b <= 1'b1;
      repeat (4) @(negedge mclk);
      t_reset();
      t_config();
      t_run();
      t_duty_off();
      t_soft_reset();
      tally_and_finish();
   end
endmodule // tb_top
`default_nettype wire
